//--- adc_ctrl_defs.svh
// Offsets, field positions, reset values and timing counts of the control
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

`define FRAME_BITS 16
`define REG_LOAD_FALL 11
`define CTRL_LOAD_RISE 15
`define TRACK_RISE 14

`define SEL_CONTROL 2'b00
`define SEL_RANGE_LO 2'b01
`define SEL_RANGE_HI 2'b10
`define SEL_SEQUENCE 2'b11

`define CTRL_ADD_MSB 11
`define CTRL_ADD_LSB 9
`define CTRL_MODE_MSB 8
`define CTRL_MODE_LSB 7
`define CTRL_PM_UPPER 6
`define CTRL_PM_LOWER 5
`define CTRL_CODING 4
`define CTRL_REF 3
`define CTRL_SEQ_UPPER 2
`define CTRL_SEQ_LOWER 1
`define CTRL_WEAK 0

`define CTRL_RESET 12'h000
`define RANGE_RESET 8'h00
`define SEQUENCE_RESET 8'h00

`define CLK_MHZ 25
`define SHUTDOWN_WAKE_US 500
`define REF_SETTLE_US 500
`define STANDBY_WAKE_NS 750
`define STANDBY_WAKE_CYCLES ((`STANDBY_WAKE_NS * `CLK_MHZ + 999) / 1000)

`endif

//--- adc_ctrl_pkg.sv
// Types shared by the converter control modules
package adc_ctrl_pkg;

  typedef enum logic [1:0] {
    SEQ_SINGLE = 2'b00,
    SEQ_PROGRAMMED = 2'b01,
    SEQ_CONSECUTIVE = 2'b10,
    SEQ_SINGLE_ALT = 2'b11
  } seq_mode_type;

  typedef enum logic [4:0] {
    PWR_AWAKE = 5'b00001,
    PWR_WAKING = 5'b00010,
    PWR_FULL_OFF = 5'b00100,
    PWR_AUTO_OFF = 5'b01000,
    PWR_STANDBY = 5'b10000
  } power_state_type;

endpackage : adc_ctrl_pkg

//--- seq_if.sv
// Signals between the frame control and the channel sequencer
`timescale 1ns/1ps
interface seq_if;
  adc_ctrl_pkg::seq_mode_type mode;
  logic [2:0] final_channel;
  logic [7:0] channel_set;
  logic restart;
  logic advance;
  logic [2:0] channel;

  modport ctrl (
    output mode, final_channel, channel_set, restart, advance,
    input channel
  );
  modport seq (
    input mode, final_channel, channel_set, restart, advance,
    output channel
  );
endinterface : seq_if

//--- pin_sync.sv
// Two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic pin_i,
  input wire logic idle_level_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta;
  logic stable;
  logic last;

  // Idle level is a constant tie-off, so reset still loads constants
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= 1'b1;
      stable <= 1'b1;
      last <= 1'b1;
    end else begin
      meta <= pin_i;
      stable <= meta;
      last <= stable;
    end
  end

  assign level_o = stable;
  assign rise_o = stable & ~last;
  assign fall_o = ~stable & last & idle_level_i;
endmodule : pin_sync

//--- channel_sequencer.sv
// Picks the channel for each conversion from the sequencer mode
`timescale 1ns/1ps
module channel_sequencer (
  input wire logic clk_i,
  input wire logic resetn_i,
  seq_if.seq bus
);
  logic [2:0] current;
  logic from_first;
  logic [2:0] lowest_set;
  logic [2:0] next_set;
  logic [2:0] next_consec;
  logic [2:0] next_channel;

  function automatic logic [2:0] find_above(input logic [7:0] set,
                                            input logic [2:0] start,
                                            input logic from_zero);
    logic [2:0] pick;
    logic found;
    pick = 3'h0;
    found = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (!found && set[i] && (from_zero || i > int'(start))) begin
        pick = 3'(i);
        found = 1'b1;
      end
    end
    if (!found) begin
      pick = find_low(set);
    end
    return pick;
  endfunction : find_above

  function automatic logic [2:0] find_low(input logic [7:0] set);
    logic [2:0] pick;
    pick = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (set[i]) begin
        pick = 3'(i);
      end
    end
    return pick;
  endfunction : find_low

  assign lowest_set = find_low(bus.channel_set);
  assign next_set = find_above(bus.channel_set, current, 1'b0);
  // Run ends on the final channel and wraps to channel 0
  assign next_consec = (current >= bus.final_channel) ? 3'h0 :
                       3'(current + 3'h1);

  always_comb begin
    unique case (bus.mode)
      adc_ctrl_pkg::SEQ_PROGRAMMED:
        next_channel = from_first ? lowest_set : next_set;
      adc_ctrl_pkg::SEQ_CONSECUTIVE:
        next_channel = from_first ? 3'h0 : next_consec;
      default:
        next_channel = bus.final_channel;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      current <= 3'h0;
      from_first <= 1'b1;
    end else if (bus.restart) begin
      from_first <= 1'b1;
    end else if (bus.advance) begin
      current <= next_channel;
      from_first <= 1'b0;
    end
  end

  assign bus.channel = next_channel;
endmodule : channel_sequencer

//--- adc_control.sv
// Serial frame, register, sequencer and power control of the converter
// Operation
// - Registers take defaults at power-up; every channel starts at +/-10 V.
// - Sequencer bits 0,1 keep converting the channel set continuously.
// - Restarted programmed sequence begins at the first selected channel.
// - Bits 1,0 convert channels 0 up to the address bits' final channel.
// - Consecutive run continues without writes; leave by writing bits 0,0.
// - Equal sequencer bits give single channel from the address bits.
// - Reference bit 1 picks internal 2.5 V; resets to 0, external.
// - Result of reference-enabling write invalid; reference settles 500 us.
// - Pseudo differential with address 7 converts die temperature.
// - Two power bits pick the mode; default normal, fully powered.
// - Chip-select fall starts conversion; writes load the selected register.
// - Host gives 16 clocks per frame; chip select then idles freely.
// - Power bits 1,1 fully shut down on 15th rise, keeping registers.
// - Writing 0,0 in full shutdown powers up on the 15th rise.
// - Auto-shutdown powers down in hold; chip-select rise wakes, 500 us.
// - After the woken conversion, auto-shutdown powers down at 15th rise.
// - Auto-standby powers all but the reference down at 15th rise.
// - Standby holds registers until chip-select rise, then wakes to track.
// - Range codes: 00 +/-10, 01 +/-5, 10 +/-2.5, 11 0..10 V.
// - Eight-bit channel set, one bit per channel, 1 includes it.
// - Programmed sequence ascends from lowest selected channel and repeats.
// - Control loads on 15th rise; set or range loads on 11th fall.
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_control #(
  parameter int SHUTDOWN_WAKE_CYCLES = `SHUTDOWN_WAKE_US * `CLK_MHZ,
  parameter int REF_SETTLE_CYCLES = `REF_SETTLE_US * `CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic [12:0] conv_result_i,
  output logic dout_o,
  output logic dout_oe_n_o,
  output logic conv_start_o,
  output logic track_o,
  output logic [2:0] channel_o,
  output logic [1:0] range_o,
  output logic [1:0] input_config_o,
  output logic temp_select_o,
  output logic coding_o,
  output logic weak_idle_o,
  output logic ref_internal_o,
  output logic ref_settling_o,
  output logic result_invalid_o,
  output logic core_power_o,
  output logic ref_power_o,
  output logic powering_up_o
);
  localparam int STANDBY_CYCLES = `STANDBY_WAKE_CYCLES;

  logic cs_level;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic din_level;

  logic in_frame;
  logic [4:0] fall_count;
  logic [4:0] rise_count;
  logic [15:0] in_shift;
  logic [15:0] next_in_shift;
  logic [15:0] out_shift;
  logic out_enable;

  logic [11:0] ctrl;
  logic [15:0] ranges;
  logic [7:0] channel_set;

  logic [13:0] wake_timer;
  logic [13:0] ref_timer;
  adc_ctrl_pkg::power_state_type power_state;
  adc_ctrl_pkg::power_state_type next_power_state;
  logic [13:0] next_wake_timer;

  seq_if seq ();

  pin_sync cs_sync (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(cs_n_i),
    .idle_level_i(1'b1), .level_o(cs_level), .rise_o(cs_rise),
    .fall_o(cs_fall));

  pin_sync sclk_sync (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(sclk_i),
    .idle_level_i(1'b1), .level_o(), .rise_o(sclk_rise),
    .fall_o(sclk_fall));

  pin_sync din_sync (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(din_i),
    .idle_level_i(1'b1), .level_o(din_level), .rise_o(),
    .fall_o());

  channel_sequencer sequencer (.clk_i(clk_i), .resetn_i(resetn_i),
    .bus(seq.seq));

  // Frame edge events
  wire frame_fall = in_frame & ~cs_level & sclk_fall;
  wire frame_rise = in_frame & ~cs_level & sclk_rise;
  wire at_reg_fall = frame_fall &
                     (fall_count == 5'(`REG_LOAD_FALL - 1));
  wire at_ctrl_rise = frame_rise &
                      (rise_count == 5'(`CTRL_LOAD_RISE - 1));
  wire at_track_rise = frame_rise &
                       (rise_count == 5'(`TRACK_RISE - 1));
  wire at_last_fall = frame_fall &
                      (fall_count == 5'(`FRAME_BITS - 1));

  assign next_in_shift = {in_shift[14:0], din_level};

  // Write bit and select sit above the data bits in the shifted frame
  wire reg_write = next_in_shift[10];
  wire [1:0] reg_select = next_in_shift[9:8];
  wire ctrl_write = in_shift[14] &
                    (in_shift[13:12] == `SEL_CONTROL);
  wire load_ctrl = at_ctrl_rise & ctrl_write;
  wire [11:0] new_ctrl = in_shift[11:0];
  wire load_lo = at_reg_fall & reg_write &
                 (reg_select == `SEL_RANGE_LO);
  wire load_hi = at_reg_fall & reg_write &
                 (reg_select == `SEL_RANGE_HI);
  wire load_set = at_reg_fall & reg_write &
                  (reg_select == `SEL_SEQUENCE);
  // First-sent pair and bit belong to the lowest channel
  wire [7:0] reg_data = next_in_shift[7:0];
  wire [7:0] range_pairs = {reg_data[1:0], reg_data[3:2], reg_data[5:4],
    reg_data[7:6]};
  wire [7:0] set_bits = {reg_data[0], reg_data[1], reg_data[2], reg_data[3],
    reg_data[4], reg_data[5], reg_data[6], reg_data[7]};

  // Power bits that govern the 15th rising edge of this frame
  wire [1:0] pm_now = load_ctrl ?
                      new_ctrl[`CTRL_PM_UPPER:`CTRL_PM_LOWER] :
                      ctrl[`CTRL_PM_UPPER:`CTRL_PM_LOWER];
  wire ref_enable = load_ctrl & new_ctrl[`CTRL_REF] & ~ctrl[`CTRL_REF];
  wire [1:0] seq_bits_new = new_ctrl[`CTRL_SEQ_UPPER:`CTRL_SEQ_LOWER];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_frame <= 1'b0;
      fall_count <= 5'h00;
      rise_count <= 5'h00;
      in_shift <= 16'h0000;
    end else if (cs_fall) begin
      in_frame <= 1'b1;
      fall_count <= 5'h00;
      rise_count <= 5'h00;
      in_shift <= 16'h0000;
    end else if (cs_rise) begin
      in_frame <= 1'b0;
    end else begin
      if (frame_fall && fall_count != 5'(`FRAME_BITS)) begin
        fall_count <= 5'(fall_count + 5'h01);
        in_shift <= next_in_shift;
      end
      if (frame_rise && rise_count != 5'(`FRAME_BITS)) begin
        rise_count <= 5'(rise_count + 5'h01);
      end
    end
  end

  // Registers keep their contents through every power-down mode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl <= `CTRL_RESET;
      ranges <= {`RANGE_RESET, `RANGE_RESET};
      channel_set <= `SEQUENCE_RESET;
    end else begin
      if (load_ctrl) begin
        ctrl <= new_ctrl;
      end
      if (load_lo) begin
        ranges[7:0] <= range_pairs;
      end
      if (load_hi) begin
        ranges[15:8] <= range_pairs;
      end
      if (load_set) begin
        channel_set <= set_bits;
      end
    end
  end

  // Sequencer steps once per conversion start; mode persists w/o writes
  assign seq.mode = adc_ctrl_pkg::seq_mode_type'(
    ctrl[`CTRL_SEQ_UPPER:`CTRL_SEQ_LOWER]);
  assign seq.final_channel = ctrl[`CTRL_ADD_MSB:`CTRL_ADD_LSB];
  assign seq.channel_set = channel_set;
  assign seq.advance = cs_fall;
  assign seq.restart = load_ctrl &
                            (seq_bits_new[1] ^ seq_bits_new[0]);

  // Channel, range and result shift for the started conversion
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      channel_o <= 3'h0;
      range_o <= 2'h0;
      out_shift <= 16'h0000;
      out_enable <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= cs_fall;
      if (cs_fall) begin
        channel_o <= seq.channel;
        range_o <= ranges[{seq.channel, 1'b0} +: 2];
        out_shift <= {seq.channel, conv_result_i};
        out_enable <= 1'b1;
      end else if (cs_rise || at_last_fall) begin
        out_enable <= 1'b0;
      end else if (frame_fall) begin
        out_shift <= {out_shift[14:0], 1'b0};
      end
    end
  end

  assign dout_o = out_shift[15];
  assign dout_oe_n_o = ~out_enable;

  assign input_config_o = ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  assign coding_o = ctrl[`CTRL_CODING];
  assign weak_idle_o = ctrl[`CTRL_WEAK];
  assign ref_internal_o = ctrl[`CTRL_REF];
  assign temp_select_o = (input_config_o == 2'b11) &
                         (channel_o == 3'h7);

  // Power state on the 15th rising edge, at chip-select rise or when the wake timer ends
  always_comb begin
    next_power_state = power_state;
    next_wake_timer = wake_timer;
    if (at_ctrl_rise) begin
      unique case (pm_now)
        2'b11: next_power_state = adc_ctrl_pkg::PWR_FULL_OFF;
        2'b10: next_power_state = adc_ctrl_pkg::PWR_AUTO_OFF;
        2'b01: next_power_state = adc_ctrl_pkg::PWR_STANDBY;
        2'b00: begin
          if (power_state == adc_ctrl_pkg::PWR_FULL_OFF) begin
            next_power_state = adc_ctrl_pkg::PWR_WAKING;
            next_wake_timer = 14'(SHUTDOWN_WAKE_CYCLES - 1);
          end else if (power_state != adc_ctrl_pkg::PWR_WAKING) begin
            next_power_state = adc_ctrl_pkg::PWR_AWAKE;
          end
        end
      endcase
    end else begin
      unique case (power_state)
        adc_ctrl_pkg::PWR_AUTO_OFF: begin
          if (cs_rise) begin
            next_power_state = adc_ctrl_pkg::PWR_WAKING;
            next_wake_timer = 14'(SHUTDOWN_WAKE_CYCLES - 1);
          end
        end
        adc_ctrl_pkg::PWR_STANDBY: begin
          if (cs_rise) begin
            next_power_state = adc_ctrl_pkg::PWR_WAKING;
            next_wake_timer = 14'(STANDBY_CYCLES - 1);
          end
        end
        adc_ctrl_pkg::PWR_WAKING: begin
          if (wake_timer == 14'h0000) begin
            next_power_state = adc_ctrl_pkg::PWR_AWAKE;
          end else begin
            next_wake_timer = 14'(wake_timer - 14'h0001);
          end
        end
        adc_ctrl_pkg::PWR_AWAKE: next_power_state = power_state;
        adc_ctrl_pkg::PWR_FULL_OFF: next_power_state = power_state;
        default: next_power_state = adc_ctrl_pkg::PWR_AWAKE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      power_state <= adc_ctrl_pkg::PWR_AWAKE;
      wake_timer <= 14'h0000;
    end else begin
      power_state <= next_power_state;
      wake_timer <= next_wake_timer;
    end
  end

  // Hold from conversion start; auto modes stay in hold until cs rise
  wire auto_down = (next_power_state == adc_ctrl_pkg::PWR_AUTO_OFF) |
                   (next_power_state == adc_ctrl_pkg::PWR_STANDBY);
  wire auto_held = ctrl[`CTRL_PM_UPPER] ^ ctrl[`CTRL_PM_LOWER];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      track_o <= 1'b1;
    end else if (cs_fall) begin
      track_o <= 1'b0;
    end else if (cs_rise) begin
      track_o <= 1'b1;
    end else if (at_ctrl_rise) begin
      track_o <= ~auto_down;
    end else if (at_track_rise && !auto_held) begin
      track_o <= 1'b1;
    end
  end

  assign core_power_o = (power_state == adc_ctrl_pkg::PWR_AWAKE) |
                        (power_state == adc_ctrl_pkg::PWR_WAKING);
  assign powering_up_o = (power_state == adc_ctrl_pkg::PWR_WAKING);
  // Standby keeps the internal reference alive for a fast wake
  assign ref_power_o = ref_internal_o &
                       (core_power_o |
                        (power_state == adc_ctrl_pkg::PWR_STANDBY));

  // Reference buffer settling after the enabling write
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_timer <= 14'h0000;
      ref_settling_o <= 1'b0;
      result_invalid_o <= 1'b0;
    end else begin
      if (ref_enable) begin
        ref_timer <= 14'(REF_SETTLE_CYCLES - 1);
        ref_settling_o <= 1'b1;
      end else if (ref_timer != 14'h0000) begin
        ref_timer <= 14'(ref_timer - 14'h0001);
      end else begin
        ref_settling_o <= 1'b0;
      end
      if (ref_enable) begin
        result_invalid_o <= 1'b1;
      end else if (cs_fall) begin
        result_invalid_o <= 1'b0;
      end
    end
  end
endmodule : adc_control

//--- adc_ctrl_pkg_unused_guard.sv
// Left empty on purpose
`timescale 1ns/1ps

//--- adc_control_chk.sv
// Port-level checks of the converter control
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_control_chk #(
  parameter int SHUTDOWN_WAKE_CYCLES = 12500,
  parameter int REF_SETTLE_CYCLES = 12500
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic dout_oe_n_o,
  input wire logic conv_start_o,
  input wire logic track_o,
  input wire logic [2:0] channel_o,
  input wire logic [1:0] input_config_o,
  input wire logic temp_select_o,
  input wire logic ref_internal_o,
  input wire logic ref_settling_o,
  input wire logic result_invalid_o,
  input wire logic core_power_o,
  input wire logic ref_power_o,
  input wire logic powering_up_o
);
  int wake_len;
  int settle_len;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Window lengths, since the counts exceed what repetition can unroll
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_len <= 0;
      settle_len <= 0;
    end else begin
      wake_len <= powering_up_o ? wake_len + 1 : 0;
      settle_len <= ref_settling_o ? settle_len + 1 : 0;
    end
  end
  chk_start_after_fall: assert property ($fell(cs_n_i) |-> ##[2:6] conv_start_o)
    else $error("no conversion start after chip-select fall");
  chk_start_drives_out: assert property (conv_start_o |-> !dout_oe_n_o ##1 !conv_start_o)
    else $error("start pulse without output enable or too long");
  chk_hold_on_start: assert property (conv_start_o |-> !track_o)
    else $error("track not in hold at conversion start");
  chk_track_cs_rise: assert property ($rose(cs_n_i) |-> ##[2:6] track_o && dout_oe_n_o)
    else $error("no return to track after chip-select rise");
  chk_temp_decode: assert property (temp_select_o == (input_config_o == 2'b11 && channel_o == 3'h7))
    else $error("temperature select mismatch");
  chk_ref_gate: assert property (!ref_internal_o |-> !ref_power_o)
    else $error("reference powered while external selected");
  chk_waking_core: assert property (powering_up_o |-> core_power_o)
    else $error("waking without core power");
  chk_invalid_set: assert property ($rose(ref_internal_o) |-> ##[0:1] result_invalid_o)
    else $error("result not marked invalid on reference enable");
  chk_invalid_clear: assert property (conv_start_o |-> ##[0:1] !result_invalid_o)
    else $error("invalid mark kept past next conversion");
  chk_wake_len: assert property ($fell(powering_up_o) |-> (wake_len inside {[`STANDBY_WAKE_CYCLES:`STANDBY_WAKE_CYCLES+1]} || wake_len inside {[SHUTDOWN_WAKE_CYCLES:SHUTDOWN_WAKE_CYCLES+1]}))
    else $error("wake window length wrong");
  chk_settle_len: assert property ($fell(ref_settling_o) |-> settle_len inside {[REF_SETTLE_CYCLES:REF_SETTLE_CYCLES+1]})
    else $error("reference settle window length wrong");
endmodule : adc_control_chk

bind adc_control adc_control_chk #(
  .SHUTDOWN_WAKE_CYCLES(SHUTDOWN_WAKE_CYCLES),
  .REF_SETTLE_CYCLES(REF_SETTLE_CYCLES)
) i_adc_control_chk (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i),
  .dout_oe_n_o(dout_oe_n_o), .conv_start_o(conv_start_o), .track_o(track_o),
  .channel_o(channel_o), .input_config_o(input_config_o),
  .temp_select_o(temp_select_o), .ref_internal_o(ref_internal_o),
  .ref_settling_o(ref_settling_o), .result_invalid_o(result_invalid_o),
  .core_power_o(core_power_o), .ref_power_o(ref_power_o),
  .powering_up_o(powering_up_o));

//--- serial_host_model.sv
// Host serial port driving frames into the converter
`timescale 1ns/1ps
module serial_host_model (
  input wire logic clk_i,
  input wire logic dout_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic xfer(input logic [15:0] w, input bit rest_low,
                      output logic [15:0] r);
    int i;
    if (cs_n_o == 1'b0) begin
      cs_n_o = 1'b1;
      tick(30);
    end
    tick(1);
    cs_n_o = 1'b0;
    tick(6);
    for (i = 15; i >= 0; i--) begin
      din_o = w[i];
      r[i] = dout_i;
      tick(4);
      sclk_o = 1'b0;
      tick(4);
      sclk_o = 1'b1;
    end
    // Released data line must not look held
    din_o = ~din_o;
    tick(4);
    if (!rest_low) begin
      cs_n_o = 1'b1;
      tick(30);
    end
  endtask : xfer
endmodule : serial_host_model

//--- adc_sequencer_power_control_test.sv
// Self-checking bench for the converter control
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_sequencer_power_control_test;
  logic clk_i, resetn_i, cs_n, sclk, din, dout, dout_oe_n_o, track_o;
  logic conv_start_o, temp_select_o, ref_internal_o, ref_settling_o;
  logic result_invalid_o, core_power_o, ref_power_o, powering_up_o;
  logic [12:0] conv_result_i = 13'h0000;
  logic [2:0] channel_o;
  logic [1:0] range_o, input_config_o;
  logic [1:0] rng [8];
  logic last_dout = 1'b0;
  logic dout_line;
  int fail_count = 0;
  int num_checks = 0;
  int i;
  int pseq [5] = '{2, 5, 7, 2, 5};
  // Floating output modelled as the inverse of its last driven value
  always @(posedge clk_i) if (!dout_oe_n_o) last_dout <= dout;
  assign dout_line = dout_oe_n_o ? ~last_dout : dout;
  adc_control #(.SHUTDOWN_WAKE_CYCLES(20), .REF_SETTLE_CYCLES(20))
  i_adc_control (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n),
    .sclk_i(sclk), .din_i(din), .conv_result_i(conv_result_i),
    .dout_o(dout), .dout_oe_n_o(dout_oe_n_o), .conv_start_o(conv_start_o),
    .track_o(track_o), .channel_o(channel_o), .range_o(range_o),
    .input_config_o(input_config_o), .temp_select_o(temp_select_o),
    .coding_o(), .weak_idle_o(), .ref_internal_o(ref_internal_o),
    .ref_settling_o(ref_settling_o), .result_invalid_o(result_invalid_o),
    .core_power_o(core_power_o), .ref_power_o(ref_power_o),
    .powering_up_o(powering_up_o));
  serial_host_model i_serial_host_model (.clk_i(clk_i), .dout_i(dout_line),
    .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  function automatic logic [15:0] ctl(input logic [2:0] a,
    input logic [1:0] md, input logic [1:0] pm, input logic rf,
    input logic [1:0] sq);
    return {1'b1, `SEL_CONTROL, a, md, pm, 1'b0, rf, sq, 2'b00};
  endfunction : ctl
  function automatic logic [15:0] wr8(input logic [1:0] sel,
    input logic [7:0] d);
    return {1'b1, sel, d, 5'h00};
  endfunction : wr8
  // One frame; ch below zero skips the channel and data checks
  task automatic conv(input logic [15:0] w, input bit rest, input int ch);
    logic [15:0] rd;
    logic [12:0] res;
    res = {w[12:5], 5'h15} ^ 13'(ch);
    conv_result_i = res;
    i_serial_host_model.xfer(w, rest, rd);
    if (ch >= 0) begin
      check("channel", 16'(ch), 16'(channel_o));
      check("range", 16'(rng[ch]), 16'(range_o));
      check("read data", {3'(ch), res}, rd);
    end
  endtask : conv
  initial begin
    resetn_i = 1'b0;
    foreach (rng[k]) rng[k] = 2'b00;
    repeat (10) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    check("range", 16'h0000, 16'(range_o));
    check("ref", 16'h0000, 16'(ref_internal_o));
    check("power", 16'h0002, 16'({core_power_o, powering_up_o}));
    conv(wr8(`SEL_RANGE_LO, 8'h1b), 0, 0);
    for (i = 0; i < 4; i++) rng[i] = 2'(8'h1b >> (6 - 2 * i));
    conv(wr8(`SEL_RANGE_HI, 8'he4), 0, 0);
    for (i = 0; i < 4; i++) rng[i + 4] = 2'(8'he4 >> (6 - 2 * i));
    for (i = 0; i <= 8; i++) begin
      conv(ctl(3'(i), 2'b00, 2'b00, 1'b0, i % 2 ? 2'b11 : 2'b00), 0,
           i == 0 ? 0 : i - 1);
    end
    conv(wr8(`SEL_SEQUENCE, 8'h25), 0, 0);
    conv(ctl(3'h0, 2'b00, 2'b00, 1'b0, 2'b01), 0, 0);
    for (i = 0; i < 5; i++) conv(16'h0000, 0, pseq[i]);
    conv(ctl(3'h0, 2'b00, 2'b00, 1'b0, 2'b00), 0, 7);
    conv(wr8(`SEL_RANGE_LO, 8'h00), 0, 0);
    for (i = 0; i < 4; i++) rng[i] = 2'b00;
    conv(ctl(3'h0, 2'b00, 2'b00, 1'b0, 2'b01), 0, 0);
    conv(16'h0000, 0, 2);
    conv(ctl(3'h3, 2'b00, 2'b00, 1'b0, 2'b10), 0, 5);
    for (i = 0; i < 6; i++) conv(16'h0000, 0, i % 4);
    conv(ctl(3'h0, 2'b00, 2'b00, 1'b0, 2'b00), 0, 2);
    // Temperature frames use the same 30-cycle chip-select gap as every other frame
    conv(ctl(3'h7, 2'b11, 2'b00, 1'b1, 2'b00), 0, 0);
    check("ref", 16'h0001, 16'(ref_internal_o));
    check("invalid", 16'h0001, 16'(result_invalid_o));
    conv(16'h0000, 0, 7);
    check("temp", 16'h0001, 16'(temp_select_o));
    check("invalid", 16'h0000, 16'(result_invalid_o));
    conv(ctl(3'h0, 2'b00, 2'b11, 1'b1, 2'b00), 0, 7);
    check("power", 16'h0000, 16'({core_power_o, ref_power_o}));
    conv(16'h0000, 0, -1);
    check("power", 16'h0000, 16'(core_power_o));
    conv(ctl(3'h0, 2'b00, 2'b00, 1'b1, 2'b00), 0, -1);
    check("power", 16'h0001, 16'(core_power_o));
    conv(ctl(3'h0, 2'b00, 2'b10, 1'b1, 2'b00), 1, 0);
    check("power", 16'h0000, 16'({core_power_o, track_o}));
    conv(16'h0000, 1, 0);
    check("power", 16'h0000, 16'(core_power_o));
    conv(ctl(3'h0, 2'b00, 2'b01, 1'b1, 2'b00), 1, 0);
    check("power", 16'h0001, 16'({core_power_o, ref_power_o}));
    conv(ctl(3'h0, 2'b00, 2'b00, 1'b1, 2'b00), 0, 0);
    check("power", 16'h0002, 16'({core_power_o, powering_up_o}));
    test_done();
  end
  initial begin
    #1000000;
    fail_count++;
    test_done();
  end
endmodule : adc_sequencer_power_control_test
